//--- hdl/mdf_pkg.sv
// package for the motor driver fault response block
package mdf_pkg;
   // register offsets (word index == byte address / 4 not used; byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
   localparam logic [7:0] ADDR_THRESH = 8'h14;
   localparam logic [7:0] ADDR_BRIDGE = 8'h18;
   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_TMO_EN_BIT = 4;
   localparam int CTRL_CLR_BIT = 5;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] THRESH_RESET = 16'hFFFF;
   // status bit positions
   localparam int ST_CTRL_FAULT = 0;
   localparam int ST_DRV_FAULT = 1;
   localparam int ST_LOCK = 2;
   localparam int ST_TMO1 = 3;
   localparam int ST_TMO2 = 4;
   localparam int ST_RATE = 5;
   localparam int ST_PUMP_UV = 6;
   localparam int NUM_EVT = 7;
   // action selections of the software lock limit
   localparam logic [3:0] MODE_REPORT = 4'h8;
   // timing
   localparam int CLK_MHZ = 125;
   localparam int PD_TIMEOUT_MS = 500;
   localparam int PD_TIMEOUT_CYC = PD_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int LOCK_RETRY_MS = 1000;
   localparam int LOCK_RETRY_CYC = LOCK_RETRY_MS * 1000 * CLK_MHZ;
   // bridge states
   typedef enum logic [2:0] {
      MDF_BR_ACTIVE,
      MDF_BR_HIZ,
      MDF_BR_RECIRC,
      MDF_BR_HS_BRAKE,
      MDF_BR_LS_BRAKE
   } mdf_bridge_t;
   // analog supply monitor levels
   typedef struct packed {
      logic motor_supply_uv;
      logic analog_reg_uv;
      logic buck_uv;
      logic pump_uv;
   } mdf_supply_t;
   // position detect activity
   typedef struct packed {
      logic ramp_active;
      logic pulse_start;
      logic current_decayed;
   } mdf_detect_t;
   // lock fault handling state
   typedef enum logic [1:0] {
      MDF_LK_IDLE,
      MDF_LK_LATCHED,
      MDF_LK_RETRY,
      MDF_LK_REPORT
   } mdf_lock_st_t;
endpackage : mdf_pkg

//--- hdl/mdf_fault_ctrl.sv
// fault supervision and bridge response logic of the motor driver
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - 0011b lock trip: low-side brake, latched
// R2 - lock selections: latched, retry, report, ignore
// R3 - position ramp over 500ms: hi-z, latched
// R4 - pulse before decay: hi-z, latched; code checks it only while position_detect_timeout_enable is set
// R5 - motor supply low disables bridge, pump, logic
// R6 - motor supply low resets whole device
// R7 - analog regulator low disables bridge, pump, logic
// R8 - analog regulator low resets device
// R9 - buck low turns off both buck switches
// R10 - buck low resets device
// R11 - pump low: bridge off, fault pin low
// R12 - pump low sets driver and pump flags
// R13 - pump recovery is automatic, no clear
// R14 - pump flag sticks until clear command
// R15 - latched release needs condition gone plus clear
module mdf_fault_ctrl #(
   parameter int LOCK_RETRY_CYCLES = mdf_pkg::LOCK_RETRY_CYC,
   parameter int PD_TIMEOUT_CYCLES = mdf_pkg::PD_TIMEOUT_CYC,
   parameter int CUR_W = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // analog monitors, asynchronous levels
   input wire mdf_pkg::mdf_supply_t supply_mon,
   input wire mdf_pkg::mdf_detect_t detect_mon,
   input wire logic [CUR_W-1:0] sense_current,
   // outputs
   output mdf_pkg::mdf_bridge_t bridge_state,
   output logic pump_enable,
   output logic buck_hs_enable,
   output logic buck_ls_enable,
   output logic logic_reset,
   output logic fault_out_n,
   output logic irq
);
   import mdf_pkg::*;

   localparam int SYNC_W = 7;

   // two-stage synchronisers for pin levels
   logic [SYNC_W-1:0] sync1_q, sync2_q;
   always_ff @(posedge ref_clk) begin
      sync1_q <= {supply_mon, detect_mon};
      sync2_q <= sync1_q;
   end
   logic mv_uv, av_uv, bk_uv, cp_uv, ramp_s, pulse_s, decayed_s;
   assign {mv_uv, av_uv, bk_uv, cp_uv, ramp_s, pulse_s, decayed_s} = sync2_q;

   // pulse start edge, taken from the second stage only
   logic pulse_d1_q;
   always_ff @(posedge ref_clk) begin
      pulse_d1_q <= rst ? 1'b0 : pulse_s;
   end
   wire pulse_rise = pulse_s & ~pulse_d1_q;

   // any supply lockout acts as a device reset
   wire dev_rst = rst | mv_uv | av_uv | bk_uv; // R6 R8 R10

   // registers
   logic [31:0] ctrl_q;
   logic [CUR_W-1:0] thresh_q;
   logic [NUM_EVT-1:0] status_q, irq_st_q, irq_en_q;
   wire wr_ctrl = reg_wr & (reg_addr == ADDR_CTRL);
   wire wr_clr = reg_wr & (reg_addr == ADDR_IRQ_CLR);
   wire wr_en = reg_wr & (reg_addr == ADDR_IRQ_EN);
   wire wr_thr = reg_wr & (reg_addr == ADDR_THRESH);
   wire clear_fault_cmd = wr_ctrl & reg_wdata[CTRL_CLR_BIT];
   wire [3:0] sw_lock_action_select = ctrl_q[CTRL_MODE_LSB +: 4];
   wire position_detect_timeout_enable = ctrl_q[CTRL_TMO_EN_BIT];
   wire [CUR_W-1:0] sw_lock_current_threshold = thresh_q;

   // lock limit decode
   wire lock_trip = sense_current > sw_lock_current_threshold;
   wire mode_ignore = sw_lock_action_select[3] & sw_lock_action_select[0]; // R2
   wire mode_report = sw_lock_action_select == MODE_REPORT; // R2
   wire mode_retry = sw_lock_action_select[3:2] == 2'b01; // R2
   wire mode_latch = sw_lock_action_select[3:2] == 2'b00; // R2

   // map selection bits 1:0 to a bridge state
   function automatic mdf_bridge_t lock_bridge(input logic [1:0] sel);
      unique case (sel)
         2'b00: lock_bridge = MDF_BR_HIZ;
         2'b01: lock_bridge = MDF_BR_RECIRC;
         2'b10: lock_bridge = MDF_BR_HS_BRAKE;
         2'b11: lock_bridge = MDF_BR_LS_BRAKE; // R1
      endcase
   endfunction : lock_bridge

   // lock fault machine with retry timer
   mdf_lock_st_t lk_q;
   logic [31:0] retry_cnt_q;
   logic [1:0] lk_sel_q;
   wire retry_done = retry_cnt_q == 32'(LOCK_RETRY_CYCLES - 1);
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         lk_q <= MDF_LK_IDLE;
         retry_cnt_q <= 32'h0000_0000;
         lk_sel_q <= 2'h0;
      end else begin
         unique case (lk_q)
            MDF_LK_IDLE: begin
               retry_cnt_q <= 32'h0000_0000;
               lk_sel_q <= sw_lock_action_select[1:0];
               if (lock_trip & ~mode_ignore) begin
                  if (mode_latch) lk_q <= MDF_LK_LATCHED; // R1 R2
                  else if (mode_retry) lk_q <= MDF_LK_RETRY; // R2
                  else if (mode_report) lk_q <= MDF_LK_REPORT; // R2
               end
            end
            // release only when the trip is gone and clear arrives
            MDF_LK_LATCHED, MDF_LK_REPORT: begin
               if (clear_fault_cmd & ~lock_trip) lk_q <= MDF_LK_IDLE; // R15
            end
            MDF_LK_RETRY: begin
               retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
               if (retry_done) lk_q <= MDF_LK_IDLE; // R2
            end
         endcase
      end
   end
   wire lock_active = lk_q != MDF_LK_IDLE;
   wire lock_drives = (lk_q == MDF_LK_LATCHED) | (lk_q == MDF_LK_RETRY);

   // position detect ramp timer and latched faults
   logic [31:0] ramp_cnt_q;
   logic tmo_q, rate_q;
   wire tmo_hit = position_detect_timeout_enable & ramp_s &
                  (ramp_cnt_q == 32'(PD_TIMEOUT_CYCLES - 1)); // R3
   wire rate_hit = position_detect_timeout_enable & pulse_rise & ~decayed_s; // R4
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         ramp_cnt_q <= 32'h0000_0000;
         tmo_q <= 1'b0;
         rate_q <= 1'b0;
      end else begin
         // counter holds at limit while the timeout is enabled; restarts with every new ramp
         if (!ramp_s) ramp_cnt_q <= 32'h0000_0000;
         else if (!tmo_hit) ramp_cnt_q <= ramp_cnt_q + 32'h0000_0001;
         // set wins over a clear in the same cycle
         tmo_q <= tmo_hit | (tmo_q & ~(clear_fault_cmd & ~ramp_s)); // R3 R15
         rate_q <= rate_hit | (rate_q & ~clear_fault_cmd); // R4 R15
      end
   end

   // status flags, sticky until clear command
   logic [NUM_EVT-1:0] st_set;
   // fault levels that the clear itself ends must not re-arm their flag in the
   // clearing cycle; a fault that persists sets the flag again one cycle later
   wire lvl_mask = ~clear_fault_cmd;
   assign st_set[ST_CTRL_FAULT] = (lock_active | tmo_q | rate_q) & lvl_mask;
   assign st_set[ST_DRV_FAULT] = cp_uv; // R12
   assign st_set[ST_LOCK] = lock_active & lvl_mask;
   assign st_set[ST_TMO1] = tmo_hit & ramp_s;
   assign st_set[ST_TMO2] = 1'b0;
   assign st_set[ST_RATE] = rate_hit;
   assign st_set[ST_PUMP_UV] = cp_uv; // R12
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         status_q <= '0;
      end else begin
         status_q <= st_set | (status_q & ~{NUM_EVT{clear_fault_cmd}}); // R14
      end
   end

   // interrupt sticky bits, enable and write-one clear
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         irq_st_q <= '0;
         irq_en_q <= '0;
      end else begin
         irq_st_q <= (st_set & ~status_q) |
                     (irq_st_q & ~(wr_clr ? reg_wdata[NUM_EVT-1:0] : '0));
         if (wr_en) irq_en_q <= reg_wdata[NUM_EVT-1:0];
      end
   end
   assign irq = |(irq_st_q & irq_en_q);

   // software registers
   always_ff @(posedge ref_clk) begin
      if (dev_rst) begin
         ctrl_q <= CTRL_RESET;
         thresh_q <= THRESH_RESET[CUR_W-1:0];
      end else begin
         if (wr_ctrl) ctrl_q <= reg_wdata & ~(32'h0000_0001 << CTRL_CLR_BIT);
         if (wr_thr) thresh_q <= reg_wdata[CUR_W-1:0];
      end
   end

   // bridge priority: lockouts, pump low, position faults, lock action
   mdf_bridge_t br_d;
   assign br_d = (dev_rst | cp_uv) ? MDF_BR_HIZ : // R5 R7 R11 R13
                 (tmo_q | rate_q) ? MDF_BR_HIZ : // R3 R4
                 lock_drives ? lock_bridge(lk_sel_q) : MDF_BR_ACTIVE; // R1 R2
   wire fault_d = cp_uv | tmo_q | rate_q | lock_active; // R11 R13
   always_ff @(posedge ref_clk) begin
      bridge_state <= br_d;
      fault_out_n <= dev_rst ? 1'b1 : ~fault_d;
      pump_enable <= ~(mv_uv | av_uv) & ~rst; // R5 R7
      buck_hs_enable <= ~bk_uv & ~rst; // R9
      buck_ls_enable <= ~bk_uv & ~rst; // R9
      logic_reset <= dev_rst; // R5 R6 R7 R8 R10
   end

   // read data, one cycle after the strobe
   logic [31:0] rd_d;
   assign rd_d = (reg_addr == ADDR_CTRL) ? ctrl_q :
                 (reg_addr == ADDR_STATUS) ? 32'(status_q) :
                 (reg_addr == ADDR_IRQ_STAT) ? 32'(irq_st_q) :
                 (reg_addr == ADDR_IRQ_EN) ? 32'(irq_en_q) :
                 (reg_addr == ADDR_THRESH) ? 32'(thresh_q) :
                 (reg_addr == ADDR_BRIDGE) ? 32'(br_d) : 32'h0000_0000;
   always_ff @(posedge ref_clk) begin
      reg_rdata <= (reg_rd & ~rst) ? rd_d : 32'h0000_0000;
   end

   // checks
   property p_pump_fault;
      @(posedge ref_clk) disable iff (rst) cp_uv |=> !fault_out_n && bridge_state == MDF_BR_HIZ;
   endproperty
   a_pump_fault: assert property (p_pump_fault) else $error("pump low not seen"); // R11
   property p_pump_flag;
      @(posedge ref_clk) disable iff (dev_rst) cp_uv |=> status_q[ST_PUMP_UV] && status_q[ST_DRV_FAULT];
   endproperty
   a_pump_flag: assert property (p_pump_flag) else $error("pump flags not set"); // R12
   property p_pump_sticky;
      @(posedge ref_clk) disable iff (dev_rst)
         status_q[ST_PUMP_UV] && !clear_fault_cmd |=> status_q[ST_PUMP_UV];
   endproperty
   a_pump_sticky: assert property (p_pump_sticky) else $error("pump flag lost"); // R14
   property p_ls_brake;
      @(posedge ref_clk) disable iff (dev_rst)
         lk_q == MDF_LK_IDLE && lock_trip && sw_lock_action_select == 4'h3
         |=> ##1 bridge_state == MDF_BR_LS_BRAKE && !fault_out_n;
   endproperty
   a_ls_brake: assert property (p_ls_brake) else $error("no low-side brake"); // R1
   property p_latch_hold;
      @(posedge ref_clk) disable iff (dev_rst)
         lk_q == MDF_LK_LATCHED && !clear_fault_cmd |=> lk_q == MDF_LK_LATCHED;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch released"); // R15
   property p_ignore;
      @(posedge ref_clk) disable iff (dev_rst)
         lk_q == MDF_LK_IDLE && mode_ignore |=> lk_q == MDF_LK_IDLE;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored mode acted"); // R2
   property p_rate;
      @(posedge ref_clk) disable iff (dev_rst) rate_hit |=> rate_q ##1 bridge_state == MDF_BR_HIZ;
   endproperty
   a_rate: assert property (p_rate) else $error("pulse rate fault missed"); // R4
   property p_lockout;
      @(posedge ref_clk) mv_uv |=> logic_reset && !pump_enable && bridge_state == MDF_BR_HIZ;
   endproperty
   a_lockout: assert property (p_lockout) else $error("lockout not applied"); // R5
   property p_buck;
      @(posedge ref_clk) bk_uv |=> !buck_hs_enable && !buck_ls_enable && logic_reset;
   endproperty
   a_buck: assert property (p_buck) else $error("buck not off"); // R9
   // ramp timeout latches and takes the bridge to hi-z
   property p_tmo_fault;
      @(posedge ref_clk) disable iff (dev_rst)
         tmo_hit |=> tmo_q ##1 bridge_state == MDF_BR_HIZ && !fault_out_n;
   endproperty
   a_tmo_fault: assert property (p_tmo_fault) else $error("ramp timeout missed"); // R3
   // timeout holds while the ramp runs or no clear arrives
   property p_tmo_hold;
      @(posedge ref_clk) disable iff (dev_rst)
         tmo_q && (!clear_fault_cmd || ramp_s) |=> tmo_q;
   endproperty
   a_tmo_hold: assert property (p_tmo_hold) else $error("timeout released early"); // R15
   // pulse rate fault holds until a clear
   property p_rate_hold;
      @(posedge ref_clk) disable iff (dev_rst)
         rate_q && !clear_fault_cmd |=> rate_q;
   endproperty
   a_rate_hold: assert property (p_rate_hold) else $error("rate fault released early"); // R15
   // with no fault left the bridge drives and the pin is released, no clear needed
   property p_pump_recover;
      @(posedge ref_clk) disable iff (dev_rst)
         !cp_uv && !tmo_q && !rate_q && !lock_active |=> fault_out_n && bridge_state == MDF_BR_ACTIVE;
   endproperty
   a_pump_recover: assert property (p_pump_recover) else $error("no recovery"); // R13
   // analog regulator low: bridge, pump and logic off
   property p_analog_lockout;
      @(posedge ref_clk)
         av_uv |=> logic_reset && !pump_enable && bridge_state == MDF_BR_HIZ;
   endproperty
   a_analog_lockout: assert property (p_analog_lockout) else $error("analog lockout missed"); // R7 R8
   // buck low clears the status flags and lock state like a reset
   property p_buck_reset;
      @(posedge ref_clk)
         bk_uv |=> status_q == '0 && lk_q == MDF_LK_IDLE && logic_reset;
   endproperty
   a_buck_reset: assert property (p_buck_reset) else $error("buck reset missed"); // R10
   // motor supply low returns the registers to reset values
   property p_motor_reset;
      @(posedge ref_clk)
         mv_uv |=> ctrl_q == CTRL_RESET && thresh_q == THRESH_RESET[CUR_W-1:0] && !irq;
   endproperty
   a_motor_reset: assert property (p_motor_reset) else $error("motor reset missed"); // R6
   // retry ends once its time has run out
   property p_retry_end;
      @(posedge ref_clk) disable iff (dev_rst)
         lk_q == MDF_LK_RETRY && retry_done |=> lk_q == MDF_LK_IDLE;
   endproperty
   a_retry_end: assert property (p_retry_end) else $error("retry did not end"); // R2
   // report only: pin low, bridge keeps driving
   property p_report_pin;
      @(posedge ref_clk) disable iff (dev_rst)
         lk_q == MDF_LK_REPORT && !cp_uv && !tmo_q && !rate_q |=> !fault_out_n && bridge_state == MDF_BR_ACTIVE;
   endproperty
   a_report_pin: assert property (p_report_pin) else $error("report mode wrong"); // R2
   // a latched lock never releases while the trip persists
   property p_latch_trip;
      @(posedge ref_clk) disable iff (dev_rst)
         lk_q == MDF_LK_LATCHED && lock_trip |=> lk_q == MDF_LK_LATCHED;
   endproperty
   a_latch_trip: assert property (p_latch_trip) else $error("released with trip"); // R15
   // clear with no new event empties the event flags
   property p_clear_flags;
      @(posedge ref_clk) disable iff (dev_rst)
         clear_fault_cmd && !cp_uv && !rate_hit && !tmo_hit |=> !status_q[ST_PUMP_UV] && !status_q[ST_RATE] && !status_q[ST_TMO1];
   endproperty
   a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared"); // R14
   // pump returns once motor supply and analog regulator are good
   property p_pump_on;
      @(posedge ref_clk)
         !mv_uv && !av_uv && !rst |=> pump_enable;
   endproperty
   a_pump_on: assert property (p_pump_on) else $error("pump stays off"); // R5
   c_latch: cover property (@(posedge ref_clk) lk_q == MDF_LK_LATCHED ##1 lk_q == MDF_LK_IDLE);
   c_retry: cover property (@(posedge ref_clk) lk_q == MDF_LK_RETRY && retry_done);
   c_tmo: cover property (@(posedge ref_clk) tmo_hit);
   c_pump: cover property (@(posedge ref_clk) cp_uv ##1 !cp_uv);
   c_report: cover property (@(posedge ref_clk) lk_q == MDF_LK_REPORT);
endmodule : mdf_fault_ctrl
`default_nettype wire

//--- tb/mdf_host_model.sv
// controller-side model that watches the fault pin
`timescale 1ns/1ps
`default_nettype none
module mdf_host_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // fault pin from the device, count of its assertions
   input wire logic fault_out_n,
   output logic [7:0] fault_cnt
);
   logic fault_q;
   // edge count; the bench clears only after the trip has gone away
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fault_q <= 1'b1;
         fault_cnt <= 8'h00;
      end else begin
         fault_q <= fault_out_n;
         if (fault_q && !fault_out_n) begin
            fault_cnt <= fault_cnt + 8'h01;
         end
      end
   end
endmodule : mdf_host_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the fault supervision block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mdf_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   mdf_supply_t supply_mon = '0;
   mdf_detect_t detect_mon = 3'h1;
   logic [15:0] sense_current = 16'h0000;
   mdf_bridge_t bridge_state;
   logic pump_enable, buck_hs_enable, buck_ls_enable, logic_reset;
   logic fault_out_n, irq;
   logic [7:0] fault_cnt;
   int num_errors = 0;
   int tests_run = 0;
   // short retry and timeout counts keep the run brief
   mdf_fault_ctrl #(.LOCK_RETRY_CYCLES(20), .PD_TIMEOUT_CYCLES(50), .CUR_W(16)) i_mdf_fault_ctrl (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_mon(supply_mon),
      .detect_mon(detect_mon), .sense_current(sense_current), .bridge_state(bridge_state),
      .pump_enable(pump_enable), .buck_hs_enable(buck_hs_enable),
      .buck_ls_enable(buck_ls_enable), .logic_reset(logic_reset),
      .fault_out_n(fault_out_n), .irq(irq));
   mdf_host_model i_mdf_host_model (.ref_clk(ref_clk), .rst(rst),
      .fault_out_n(fault_out_n), .fault_cnt(fault_cnt));
   // 125 MHz
   always #4 ref_clk = ~ref_clk;
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // inputs move 1 ns after the edge so no race with the design
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rdc
   task automatic pins(input mdf_bridge_t br, input logic fn);
      chk({28'h0, bridge_state, fault_out_n}, {28'h0, br, fn});
   endtask : pins
   // watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      $display("mismatch at %0t: run timed out", $time);
      report_and_stop();
   end
   initial begin
      tick(6);
      rst <= 1'b0;
      tick(3);
      rdc(ADDR_THRESH, 32'h0000FFFF);
      rdc(ADDR_CTRL, 32'h0);
      rdc(8'h1C, 32'h0);
      wr(ADDR_THRESH, 32'h0100);
      // every lock action selection; 1010b, 1100b, 1110b are undefined and skipped
      for (int m = 0; m < 16; m++) begin
         logic [3:0] md;
         md = 4'(m);
         if (md[3] && !md[0] && md != MODE_REPORT) continue;
         wr(ADDR_CTRL, {28'h0, md});
         sense_current <= 16'h0100;
         tick(4);
         pins(MDF_BR_ACTIVE, 1'b1);
         sense_current <= 16'h0101;
         tick(4);
         if (md[3] && md[0]) pins(MDF_BR_ACTIVE, 1'b1);
         else if (md[3]) pins(MDF_BR_ACTIVE, 1'b0);
         else pins(mdf_bridge_t'(3'(md[1:0]) + 3'h1), 1'b0);
         if (md == 4'h3) rdc(ADDR_STATUS, 32'h05);
         sense_current <= 16'h0000;
         tick(4);
         if (md[2] && !md[3]) begin
            tick(25);
            pins(MDF_BR_ACTIVE, 1'b1);
         end else if (!md[0] || !md[3]) begin
            pins(md[3] ? MDF_BR_ACTIVE : mdf_bridge_t'(3'(md[1:0]) + 3'h1), 1'b0);
         end
         wr(ADDR_CTRL, {26'h0, 2'b10, md});
         tick(4);
         pins(MDF_BR_ACTIVE, 1'b1);
      end
      chk({24'h0, fault_cnt}, 32'h9);
      // ramp timeout, first with the enable off
      for (int e = 0; e < 2; e++) begin
         wr(ADDR_CTRL, {27'h0, e[0], 4'h0});
         detect_mon.ramp_active <= 1'b1;
         tick(30);
         pins(MDF_BR_ACTIVE, 1'b1);
         tick(30);
         pins(e[0] ? MDF_BR_HIZ : MDF_BR_ACTIVE, !e[0]);
         detect_mon.ramp_active <= 1'b0;
         tick(4);
         if (e[0]) pins(MDF_BR_HIZ, 1'b0);
         if (e[0]) rdc(ADDR_STATUS, 32'h09);
         wr(ADDR_CTRL, 32'h30);
         tick(4);
         pins(MDF_BR_ACTIVE, 1'b1);
      end
      // detection pulse before the previous current decayed
      detect_mon <= 3'b010;
      tick(4);
      pins(MDF_BR_HIZ, 1'b0);
      detect_mon <= 3'b001;
      tick(4);
      rdc(ADDR_STATUS, 32'h21);
      wr(ADDR_CTRL, 32'h30);
      tick(4);
      pins(MDF_BR_ACTIVE, 1'b1);
      // pump undervoltage with its interrupt enabled, then masked
      wr(ADDR_IRQ_CLR, 32'h7F);
      wr(ADDR_IRQ_EN, 32'h40);
      tick(1);
      chk({31'h0, irq}, 32'h0);
      for (int k = 0; k < 2; k++) begin
         supply_mon.pump_uv <= 1'b1;
         tick(4);
         pins(MDF_BR_HIZ, 1'b0);
         rdc(ADDR_STATUS, 32'h42);
         chk({31'h0, irq}, {31'h0, !k[0]});
         rdc(ADDR_IRQ_STAT, k[0] ? 32'h02 : 32'h42);
         supply_mon.pump_uv <= 1'b0;
         tick(4);
         pins(MDF_BR_ACTIVE, 1'b1);
         rdc(ADDR_STATUS, 32'h42);
         wr(ADDR_IRQ_CLR, 32'h40);
         wr(ADDR_IRQ_EN, 32'h0);
         tick(1);
         chk({31'h0, irq}, 32'h0);
      end
      wr(ADDR_CTRL, 32'h20);
      rdc(ADDR_STATUS, 32'h0);
      // motor supply, analog regulator and buck lockouts
      for (int s = 0; s < 3; s++) begin
         wr(ADDR_THRESH, 32'h0100);
         supply_mon <= mdf_supply_t'(4'h8 >> s);
         tick(4);
         chk({logic_reset, pump_enable, buck_hs_enable, buck_ls_enable}, (s == 2) ? 32'hC : 32'hB);
         pins(MDF_BR_HIZ, 1'b1);
         supply_mon <= '0;
         tick(6);
         chk({logic_reset, pump_enable, buck_hs_enable, buck_ls_enable}, 32'h7);
         rdc(ADDR_THRESH, 32'h0000FFFF);
      end
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
